// [ktw_pkg.sv]
// Package for the keyed cycle timeout guard: register offset, field layout,
// key words, reset value and the exponent table.
// Assumes a 16-bit register port clocked by i_clk_sys at 10 MHz.
package ktw_pkg;
   localparam logic [7:0] WATCHDOG_CONTROL_STATUS_OFS = 8'hE6;
   localparam logic [15:0] CTRL_RESET = 16'hC080;
   localparam int RUN_BIT = 15;
   localparam int RST_SEL_BIT = 14;
   localparam int RST_FLAG_BIT = 13;
   localparam int IRQ_FLAG_BIT = 12;
   localparam int TEST_BIT = 11;
   localparam logic [15:0] UNLOCK_KEY1 = 16'h3333;
   localparam logic [15:0] UNLOCK_KEY2 = 16'hCCCC;
   localparam logic [15:0] RESTART_KEY1 = 16'hAAAA;
   localparam logic [15:0] RESTART_KEY2 = 16'h5555;
   localparam int CNT_W = 27;
   // Exponents for selection bits 0..7
   localparam int EXP_B0 = 10;
   localparam int EXP_B1 = 20;
   localparam int EXP_BASE = 19;
   // Test mode shrinks the exponent to this value
   localparam int EXP_TEST = 4;

   // Key sequence tracker
   typedef enum logic [4:0] {
      KTW_IDLE = 5'b00001,
      KTW_UNL1 = 5'b00010,
      KTW_OPEN = 5'b00100,
      KTW_RST1 = 5'b01000,
      KTW_SPARE = 5'b10000
   } ktw_key_t;

   // Control word as stored
   typedef struct packed {
      logic run;
      logic rst_sel;
      logic rst_flag;
      logic irq_flag;
      logic test;
      logic [7:0] sel;
   } ktw_ctrl_t;

   // Expiry events leaving the block
   typedef struct packed {
      logic sys_reset;
      logic nmi;
   } ktw_event_t;
endpackage : ktw_pkg

// [ktw_counter.sv]
// Cycle counter, counting while run, with a terminal match every 2^exponent cycles.
// Assumes exponent is stable or changed only after a restart.
`timescale 1ns/1ps
module ktw_counter (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic i_run,
   input wire logic i_clear,
   input wire logic [4:0] i_exp,
   input wire logic i_exp_valid,
   output logic o_expire
);
   logic [ktw_pkg::CNT_W-1:0] count;
   logic [ktw_pkg::CNT_W-1:0] next_count;
   logic [ktw_pkg::CNT_W-1:0] limit;
   logic next_expire;

   // ==========================================================
   // Counting
   // Terminal is limit-1 so one interval is exactly 2^exp cycles
   always_comb begin
      limit = {{(ktw_pkg::CNT_W-1){1'b0}}, 1'b1} << i_exp;
      next_count = count;
      next_expire = 1'b0;
      if (i_clear) begin
         next_count = '0;
      end else if (i_run && i_exp_valid) begin
         if (count >= limit - 1'b1) begin
            next_count = '0;
            next_expire = 1'b1;
         end else begin
            next_count = count + 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         count <= '0;
         o_expire <= 1'b0;
      end else begin
         count <= next_count;
         o_expire <= next_expire;
      end
   end
endmodule : ktw_counter

// [ktw_watchdog.sv]
// Keyed cycle timeout guard: control word, key tracker, expiry actions.
// Assumes register strobes are synchronous to i_clk_sys and one cycle long;
// the system reset pulse is wrapped back by the chip, not by this block.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module ktw_watchdog (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic [7:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   output logic o_sys_reset,
   output logic o_nmi
);
   ktw_pkg::ktw_key_t key;
   ktw_pkg::ktw_key_t next_key;
   ktw_pkg::ktw_ctrl_t ctrl;
   ktw_pkg::ktw_ctrl_t next_ctrl;
   ktw_pkg::ktw_event_t evt;
   ktw_pkg::ktw_event_t next_evt;
   logic [15:0] next_rdata;
   logic restart;
   logic expire;
   logic hit;
   logic key_rd;
   logic [4:0] exp_sel;
   logic exp_valid;

   assign hit = (i_addr == ktw_pkg::WATCHDOG_CONTROL_STATUS_OFS);

   // ==========================================================
   // Exponent select
   // Lowest set bit wins, so a mis-set field errs on the short side
   always_comb begin
      exp_sel = 5'(ktw_pkg::EXP_BASE + 7);
      exp_valid = |ctrl.sel;
      for (int i = 7; i >= 0; i--) begin
         if (ctrl.sel[i]) begin
            if (i == 0) begin
               exp_sel = 5'(ktw_pkg::EXP_B0);
            end else if (i == 1) begin
               exp_sel = 5'(ktw_pkg::EXP_B1);
            end else begin
               exp_sel = 5'(ktw_pkg::EXP_BASE + i);
            end
         end
      end
      if (ctrl.test) begin
         exp_sel = 5'(ktw_pkg::EXP_TEST);
      end
   end

   // ==========================================================
   // Cycle counter
   ktw_counter i_ktw_counter (
      .i_clk_sys(i_clk_sys),
      .i_arst_n(i_arst_n),
      .i_run(ctrl.run),
      .i_clear(restart || evt.sys_reset),
      .i_exp(exp_sel),
      .i_exp_valid(exp_valid),
      .o_expire(expire)
   );

   // ==========================================================
   // Key tracker and control word
   // Only accesses that hit this offset, and a guard reset expiry, move the
   // tracker, so other traffic between key halves leaves it where it was.
   always_comb begin
      next_key = key;
      next_ctrl = ctrl;
      next_evt = '0;
      restart = 1'b0;
      key_rd = i_rd && hit && (key == ktw_pkg::KTW_OPEN);
      if (i_wr && hit) begin
         // A hitting word that is not the expected next one drops the key,
         // though it may itself open a new sequence
         if (i_wdata == ktw_pkg::UNLOCK_KEY1) begin
            next_key = ktw_pkg::KTW_UNL1;
         end else if (i_wdata == ktw_pkg::RESTART_KEY1) begin
            next_key = ktw_pkg::KTW_RST1;
         end else begin
            next_key = ktw_pkg::KTW_IDLE;
         end
         case (key)
            ktw_pkg::KTW_OPEN: begin
               // Single configuration write, flags cleared by keyed write
               next_key = ktw_pkg::KTW_IDLE;
               next_ctrl.run = i_wdata[ktw_pkg::RUN_BIT];
               next_ctrl.rst_sel = i_wdata[ktw_pkg::RST_SEL_BIT];
               next_ctrl.test = i_wdata[ktw_pkg::TEST_BIT];
               next_ctrl.sel = i_wdata[7:0];
               next_ctrl.rst_flag = 1'b0;
               next_ctrl.irq_flag = 1'b0;
            end
            ktw_pkg::KTW_UNL1: begin
               if (i_wdata == ktw_pkg::UNLOCK_KEY2) begin
                  next_key = ktw_pkg::KTW_OPEN;
               end
            end
            ktw_pkg::KTW_RST1: begin
               if (i_wdata == ktw_pkg::RESTART_KEY2) begin
                  next_key = ktw_pkg::KTW_IDLE;
                  restart = 1'b1;
                  next_ctrl.rst_flag = 1'b0;
                  next_ctrl.irq_flag = 1'b0;
               end
            end
            default: begin
               // Idle and the spare code keep the start decision above
               restart = 1'b0;
            end
         endcase
      end
      // A read while the register is open counts as keyed
      if (key_rd) begin
         next_ctrl.rst_flag = 1'b0;
      end
      // Expiry actions; the event set wins over any clear above
      if (expire) begin
         if (ctrl.rst_sel || ctrl.irq_flag) begin
            next_evt.sys_reset = 1'b1;
            next_ctrl = ktw_pkg::ktw_ctrl_t'({ktw_pkg::CTRL_RESET[15:11],
                                             ktw_pkg::CTRL_RESET[7:0]});
            next_ctrl.rst_flag = 1'b1;
            next_key = ktw_pkg::KTW_IDLE;
         end else begin
            next_evt.nmi = 1'b1;
            next_ctrl.irq_flag = 1'b1;
         end
      end
   end

   // ==========================================================
   // Read data: the count is never on the bus
   always_comb begin
      next_rdata = 16'h0000;
      if (i_rd && hit) begin
         next_rdata = {ctrl.run, ctrl.rst_sel, ctrl.rst_flag, ctrl.irq_flag, ctrl.test,
                       3'h0, ctrl.sel};
      end
   end

   // State registers; reset value yields running, reset mode, longest timeout
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         key <= ktw_pkg::KTW_IDLE;
         ctrl <= ktw_pkg::ktw_ctrl_t'({ktw_pkg::CTRL_RESET[15:11],
                                       ktw_pkg::CTRL_RESET[7:0]});
         evt <= '0;
         o_rdata <= 16'h0000;
      end else begin
         key <= next_key;
         ctrl <= next_ctrl;
         evt <= next_evt;
         o_rdata <= next_rdata;
      end
   end

   assign o_sys_reset = evt.sys_reset;
   assign o_nmi = evt.nmi;

   // ==========================================================
   // Checks
   unlock_write_a:
   assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (key == ktw_pkg::KTW_OPEN && i_wr && hit && !expire)
      |=> (ctrl.sel == $past(i_wdata[7:0]) && key == ktw_pkg::KTW_IDLE))
      else $error("configuration write not taken once");
   locked_write_a:
   assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (key == ktw_pkg::KTW_IDLE && i_wr && !expire) |=> $stable(ctrl.sel))
      else $error("locked write changed the selection");
   nmi_flag_a:
   assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (expire && !ctrl.rst_sel && !ctrl.irq_flag) |=> (o_nmi && ctrl.irq_flag))
      else $error("nmi expiry did not set flag");
   reset_sel_a:
   assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (expire && (ctrl.rst_sel || ctrl.irq_flag)) |=> (o_sys_reset && !o_nmi))
      else $error("expiry did not reset system");
   reset_reload_a:
   assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      o_sys_reset |-> (ctrl.run && ctrl.rst_sel && ctrl.rst_flag && ctrl.sel == 8'h80))
      else $error("guard reset did not reload control");
   zero_sel_a:
   assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (ctrl.sel == 8'h00) |=> !expire)
      else $error("expiry with empty selection");
   stop_run_a:
   assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (!ctrl.run && !$past(ctrl.run)) |-> !expire)
      else $error("expiry while stopped");
   count_hidden_a:
   assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      $past(i_rd && hit) |-> (o_rdata[10:8] == 3'h0))
      else $error("reserved read bits not zero");
   // The bus shows nothing outside the answer cycle, so no count leaks out
   rdata_idle_a:
   assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      !$past(i_rd && hit) |-> (o_rdata == 16'h0000))
      else $error("read data outside the answer cycle");
   keyed_read_a:
   assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (key_rd && !expire) |=> !ctrl.rst_flag)
      else $error("keyed read left reset flag set");
   unlock_open_a:
   assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (key == ktw_pkg::KTW_UNL1 && i_wr && hit && !expire
       && i_wdata == ktw_pkg::UNLOCK_KEY2)
      |=> (key == ktw_pkg::KTW_OPEN))
      else $error("unlock pair did not open the word");
   restart_flags_a:
   assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (key == ktw_pkg::KTW_RST1 && i_wr && hit && !expire
       && i_wdata == ktw_pkg::RESTART_KEY2)
      |=> (!ctrl.irq_flag && !ctrl.rst_flag && key == ktw_pkg::KTW_IDLE))
      else $error("restart pair did not clear the flags");
endmodule : ktw_watchdog

// [keyed_watchdog_timer_bench.sv]
// Bench for the keyed cycle timeout guard: register tasks and expiry timing.
// Assumes ktw_watchdog with its register port at i_clk_sys, 100 ns period.
`timescale 1ns/1ps
`define CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
   $display("MISMATCH %s expected %h seen %h", what, exp, got); end end
module keyed_watchdog_timer_bench;
   logic i_clk_sys = 1'b0;
   logic i_arst_n = 1'b0;
   logic [7:0] i_addr = 8'h00;
   logic [15:0] i_wdata = 16'h0000;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [15:0] o_rdata;
   logic o_sys_reset;
   logic o_nmi;
   int n_errors = 0;
   int n_checks = 0;
   int cyc = 0;
   int a_nmi;
   int a_rst;
   localparam logic [7:0] OFS = ktw_pkg::WATCHDOG_CONTROL_STATUS_OFS;
   // ========================================
   // Clock, device and hang guard
   always #50 i_clk_sys = ~i_clk_sys;
   ktw_watchdog i_ktw_watchdog (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .o_sys_reset(o_sys_reset), .o_nmi(o_nmi));
   // Whole run needs about 4500 cycles; the ceiling leaves wide margin
   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   // ========================================
   // Bus tasks
   task automatic wr(input logic [7:0] adr, input logic [15:0] dat);
      @(posedge i_clk_sys);
      i_wr <= 1'b1;
      i_addr <= adr;
      i_wdata <= dat;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
      i_wdata <= ~dat;
   endtask : wr
   // Read data stand only in the cycle after the strobe, so sample there
   task automatic rd(input logic [7:0] adr, input logic [15:0] exp, input string what);
      @(posedge i_clk_sys);
      i_rd <= 1'b1;
      i_addr <= adr;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1;
      `CHK(what, exp, o_rdata)
   endtask : rd
   // Restart first so a shorter selection cannot expire at once
   task automatic cfg(input logic [15:0] dat);
      wr(OFS, ktw_pkg::RESTART_KEY1);
      wr(OFS, ktw_pkg::RESTART_KEY2);
      wr(OFS, ktw_pkg::UNLOCK_KEY1);
      wr(OFS, ktw_pkg::UNLOCK_KEY2);
      wr(OFS, dat);
   endtask : cfg
   // First cycle of each event pulse within a bounded window, 0 if none
   task automatic watch(input int hi, output int at_nmi, output int at_rst);
      at_nmi = 0;
      at_rst = 0;
      for (int n = 1; n <= hi; n++) begin
         @(posedge i_clk_sys);
         #1;
         if (o_nmi === 1'b1 && at_nmi == 0) at_nmi = n;
         if (o_sys_reset === 1'b1 && at_rst == 0) at_rst = n;
      end
   endtask : watch
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : tally_and_finish
   // ========================================
   // Test sequence
   initial begin
      repeat (8) @(posedge i_clk_sys);
      i_arst_n <= 1'b1;
      rd(OFS, 16'hC080, "reset value");
      wr(OFS, 16'h0001);
      rd(OFS, 16'hC080, "locked write");
      // A stray word between the key halves abandons the key
      wr(OFS, ktw_pkg::UNLOCK_KEY1);
      wr(OFS, 16'h1234);
      wr(OFS, ktw_pkg::UNLOCK_KEY2);
      wr(OFS, 16'h0001);
      rd(OFS, 16'hC080, "broken key");
      rd(8'hE2, 16'h0000, "unmapped read");
      // Other accesses between halves and before the write are harmless
      wr(OFS, ktw_pkg::RESTART_KEY1);
      wr(OFS, ktw_pkg::RESTART_KEY2);
      wr(OFS, ktw_pkg::UNLOCK_KEY1);
      wr(8'hE4, 16'hCCCC);
      rd(8'hE0, 16'h0000, "other read");
      wr(OFS, ktw_pkg::UNLOCK_KEY2);
      wr(8'hE2, 16'h0040);
      wr(OFS, 16'h8083);
      rd(OFS, 16'h8083, "config");
      wr(OFS, 16'hC080);
      rd(OFS, 16'h8083, "second write");
      // Bits 0, 1 and 7 set: the 2^10 interval wins, NMI since select is 0
      watch(1040, a_nmi, a_rst);
      `CHK("nmi time", 1'b1, (a_nmi >= 990 && a_nmi <= 1030))
      `CHK("no reset", 0, a_rst)
      rd(OFS, 16'h9083, "nmi flag");
      // Flag still set: the next expiry resets whatever the select bit says
      watch(1100, a_nmi, a_rst);
      `CHK("reset seen", 1'b1, (a_rst > 0))
      `CHK("no nmi", 0, a_nmi)
      rd(OFS, 16'hE080, "after guard reset");
      wr(OFS, ktw_pkg::UNLOCK_KEY1);
      wr(OFS, ktw_pkg::UNLOCK_KEY2);
      rd(OFS, 16'hE080, "keyed read");
      rd(OFS, 16'hC080, "flag cleared");
      // The keyed read left the word open; spend the unlock on a real write
      wr(OFS, 16'hC081);
      rd(OFS, 16'hC081, "unlock spent");
      cfg(16'h8801);
      watch(30, a_nmi, a_rst);
      `CHK("test mode", 1'b1, (a_nmi >= 4 && a_nmi <= 20))
      `CHK("test reset", 1'b1, (a_rst > a_nmi && a_rst <= 30))
      rd(OFS, 16'hE080, "test mode reset");
      // External reset mid-run clears the guard reset flag
      @(posedge i_clk_sys);
      i_arst_n <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      i_arst_n <= 1'b1;
      rd(OFS, 16'hC080, "external reset");
      cfg(16'h8000);
      rd(OFS, 16'h8000, "flags cleared");
      watch(1100, a_nmi, a_rst);
      `CHK("empty select", 0, a_nmi + a_rst)
      cfg(16'h0001);
      watch(1100, a_nmi, a_rst);
      `CHK("stopped", 0, a_nmi + a_rst)
      tally_and_finish();
   end
endmodule : keyed_watchdog_timer_bench
